// ---- logic/pal_partner_ability.v ----
// partner ability register bank with apb slave
//
// Chosen here: register access over APB.
`include "pal_defs.vh"

module pal_partner_ability (
	// clock and reset
	input  wire                     pclk,
	input  wire                     presetn,
	// apb slave
	input  wire                     psel,
	input  wire                     penable,
	input  wire                     pwrite,
	input  wire [`PAL_ADDR_W-1:0]   paddr,
	input  wire [`PAL_DATA_W-1:0]   pwdata,
	output wire [`PAL_DATA_W-1:0]   prdata,
	output wire                     pready,
	output wire                     pslverr,
	// negotiation engine
	input  wire                     page_valid,
	input  wire                     page_is_next,
	input  wire [`PAL_PAGE_W-1:0]   page_word,
	input  wire                     an_complete,
	input  wire                     an_restart,
	// status to engine
	output reg                      next_page_support_reg,
	output reg                      view_is_next_reg,
	output reg                      partner_next_page_req_reg
);

	// ------------------------------------------------------------
	// address decode
	// ------------------------------------------------------------
	// low two address bits are ignored, each register is one word
	function [`PAL_SEL_W-1:0] pal_decode;
		input [`PAL_ADDR_W-1:0] addr;
		reg   [`PAL_IDX_W-1:0]  idx;
		begin
			idx = addr[`PAL_IDX_HI:`PAL_IDX_LO];
			case (idx)
				`PAL_VIEW_INDEX: pal_decode = `PAL_SEL_VIEW;
				`PAL_CTRL_INDEX: pal_decode = `PAL_SEL_CTRL;
				`PAL_STAT_INDEX: pal_decode = `PAL_SEL_STAT;
				`PAL_BASE_INDEX: pal_decode = `PAL_SEL_BASE;
				`PAL_NEXT_INDEX: pal_decode = `PAL_SEL_NEXT;
				default:         pal_decode = `PAL_SEL_NONE;
			endcase
		end
	endfunction

	// ------------------------------------------------------------
	// ability word formatting
	// ------------------------------------------------------------
	// every field is placed by name so a stray bit cannot leak out
	function [`PAL_PAGE_W-1:0] pal_format;
		input [`PAL_PAGE_W-1:0] w;
		reg   [`PAL_PAGE_W-1:0] f;
		begin
			f = `PAL_PAGE_RST;
			f[`PAL_BIT_NP]    = w[`PAL_BIT_NP];
			f[`PAL_BIT_ACK]   = w[`PAL_BIT_ACK];
			f[`PAL_BIT_RF]    = w[`PAL_BIT_RF];
			f[`PAL_BIT_RSVD]  = `PAL_RSVD_VAL;
			f[`PAL_BIT_ASM]   = w[`PAL_BIT_ASM];
			f[`PAL_BIT_PAUSE] = w[`PAL_BIT_PAUSE];
			f[`PAL_BIT_T4]    = w[`PAL_BIT_T4];
			f[`PAL_BIT_TXFD]  = w[`PAL_BIT_TXFD];
			f[`PAL_BIT_TX]    = w[`PAL_BIT_TX];
			f[`PAL_BIT_TENFD] = w[`PAL_BIT_TENFD];
			f[`PAL_BIT_TEN]   = w[`PAL_BIT_TEN];
			f[`PAL_SEL_HI:`PAL_SEL_LO] =
				w[`PAL_SEL_HI:`PAL_SEL_LO];
			pal_format = f;
		end
	endfunction

	// ------------------------------------------------------------
	// internal signals
	// ------------------------------------------------------------
	wire [`PAL_SEL_W-1:0]   rd_sel;
	wire [`PAL_SEL_W-1:0]   wr_sel;
	wire                    access;
	wire                    wr_access;
	wire                    ctrl_wr;
	wire                    clear_pages;
	wire                    page_ok;
	wire [`PAL_PAGE_W-1:0]  base_reg;
	wire [`PAL_PAGE_W-1:0]  next_reg;
	wire                    base_valid_reg;
	wire                    next_valid_reg;
	reg  [`PAL_PAGE_W-1:0]  view_reg;
	reg  [`PAL_PAGE_W-1:0]  view_next;
	reg                     view_is_next_next;
	reg                     an_done_reg;
	reg  [`PAL_CNT_W-1:0]   page_cnt_reg;
	reg  [`PAL_CNT_W-1:0]   page_cnt_next;
	reg                     next_page_support_next;
	reg  [`PAL_DATA_W-1:0]  rd_data;
	reg                     rd_err;

	assign rd_sel    = pal_decode(paddr);
	assign wr_sel    = pal_decode(paddr);
	assign wr_access = access & pwrite;
	assign ctrl_wr   = wr_access & (wr_sel == `PAL_SEL_CTRL);
	// a restart or a software clear both drop the stored pages
	assign clear_pages = an_restart |
		(ctrl_wr & pwdata[`PAL_CTRL_CLR]);
	assign page_ok   = page_valid;

	// ------------------------------------------------------------
	// stored pages
	// ------------------------------------------------------------
	pal_page_store u_store (
		.pclk           (pclk),
		.presetn        (presetn),
		.page_valid     (page_ok),
		.page_is_next   (page_is_next),
		.page_word      (page_word),
		.clear          (clear_pages),
		.base_reg       (base_reg),
		.next_reg       (next_reg),
		.base_valid_reg (base_valid_reg),
		.next_valid_reg (next_valid_reg)
	);

	// ------------------------------------------------------------
	// control register
	// ------------------------------------------------------------
	always @* begin
		next_page_support_next = next_page_support_reg;
		if (ctrl_wr) begin
			next_page_support_next = pwdata[`PAL_CTRL_NPEN];
		end
	end

	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			next_page_support_reg <= `PAL_CTRL_RST;
		end else begin
			next_page_support_reg <= next_page_support_next;
		end
	end

	// ------------------------------------------------------------
	// negotiation completion tracking
	// ------------------------------------------------------------
	// completion is only trusted until the engine restarts
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			an_done_reg <= 1'b0;
		end else if (an_restart) begin
			an_done_reg <= 1'b0;
		end else begin
			an_done_reg <= an_complete;
		end
	end

	// ------------------------------------------------------------
	// view selection
	// ------------------------------------------------------------
	// the view switches to the next page only after completion
	always @* begin
		view_is_next_next = 1'b0;
		if (next_page_support_reg && an_done_reg &&
			next_valid_reg) begin
			view_is_next_next = 1'b1;
		end
	end

	// ------------------------------------------------------------
	// visible view word
	// ------------------------------------------------------------
	// the view is built from whole stored words, never field by
	// field, so a read cannot straddle two pages
	always @* begin
		view_next = `PAL_PAGE_RST;
		if (view_is_next_next) begin
			view_next = pal_format(next_reg);
		end else if (base_valid_reg) begin
			view_next = pal_format(base_reg);
		end
	end

	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			view_reg                  <= `PAL_PAGE_RST;
			view_is_next_reg          <= 1'b0;
			partner_next_page_req_reg <= 1'b0;
		end else begin
			view_reg                  <= view_next;
			view_is_next_reg          <= view_is_next_next;
			partner_next_page_req_reg <= view_next[`PAL_BIT_NP];
		end
	end

	// ------------------------------------------------------------
	// page counter
	// ------------------------------------------------------------
	// saturates rather than wraps so software sees activity
	always @* begin
		page_cnt_next = page_cnt_reg;
		if (an_restart) begin
			page_cnt_next = `PAL_CNT_RST;
		end else if (page_valid && page_cnt_reg != `PAL_CNT_MAX) begin
			page_cnt_next = page_cnt_reg + `PAL_CNT_ONE;
		end
	end

	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			page_cnt_reg <= `PAL_CNT_RST;
		end else begin
			page_cnt_reg <= page_cnt_next;
		end
	end

	// ------------------------------------------------------------
	// read multiplexer
	// ------------------------------------------------------------
	// writes to read-only words are accepted and dropped, only an
	// unmapped address answers with an error
	always @* begin
		rd_data = `PAL_ZERO32;
		rd_err  = 1'b0;
		case (rd_sel)
			`PAL_SEL_VIEW: begin
				rd_data[`PAL_PAGE_W-1:0] = view_reg;
			end
			`PAL_SEL_CTRL: begin
				rd_data[`PAL_CTRL_NPEN] = next_page_support_reg;
			end
			`PAL_SEL_STAT: begin
				rd_data[`PAL_ST_BASEV]  = base_valid_reg;
				rd_data[`PAL_ST_NEXTV]  = next_valid_reg;
				rd_data[`PAL_ST_VIEWN]  = view_is_next_reg;
				rd_data[`PAL_ST_ANDONE] = an_done_reg;
				rd_data[`PAL_ST_CNT_HI:`PAL_ST_CNT_LO] = page_cnt_reg;
			end
			`PAL_SEL_BASE: begin
				rd_data[`PAL_PAGE_W-1:0] = pal_format(base_reg);
			end
			`PAL_SEL_NEXT: begin
				rd_data[`PAL_PAGE_W-1:0] = pal_format(next_reg);
			end
			default: begin
				rd_err = 1'b1;
			end
		endcase
	end

	// ------------------------------------------------------------
	// apb answer
	// ------------------------------------------------------------
	// no write path reaches view_reg, so view writes are ignored
	pal_apb_port u_port (
		.pclk        (pclk),
		.presetn     (presetn),
		.psel        (psel),
		.penable     (penable),
		.rd_data     (rd_data),
		.rd_err      (rd_err),
		.pready_reg  (pready),
		.prdata_reg  (prdata),
		.pslverr_reg (pslverr),
		.access      (access)
	);

endmodule

// ---- pkg/pal_defs.vh ----
// constants for the partner ability register block
`ifndef PAL_DEFS_VH
`define PAL_DEFS_VH

// ----------------------------------------------------------------
// bus geometry
// ----------------------------------------------------------------
`define PAL_ADDR_W          12
`define PAL_DATA_W          32
`define PAL_IDX_W           10
`define PAL_IDX_HI          11
`define PAL_IDX_LO          2
`define PAL_PAGE_W          16

// ----------------------------------------------------------------
// register indices, byte address is four times the index
// ----------------------------------------------------------------
`define PAL_VIEW_INDEX      10'h005
`define PAL_CTRL_INDEX      10'h010
`define PAL_STAT_INDEX      10'h011
`define PAL_BASE_INDEX      10'h012
`define PAL_NEXT_INDEX      10'h013

// ----------------------------------------------------------------
// decode selects
// ----------------------------------------------------------------
`define PAL_SEL_W           3
`define PAL_SEL_NONE        3'h0
`define PAL_SEL_VIEW        3'h1
`define PAL_SEL_CTRL        3'h2
`define PAL_SEL_STAT        3'h3
`define PAL_SEL_BASE        3'h4
`define PAL_SEL_NEXT        3'h5

// ----------------------------------------------------------------
// ability word fields
// ----------------------------------------------------------------
`define PAL_BIT_NP          15
`define PAL_BIT_ACK         14
`define PAL_BIT_RF          13
`define PAL_BIT_RSVD        12
`define PAL_BIT_ASM         11
`define PAL_BIT_PAUSE       10
`define PAL_BIT_T4          9
`define PAL_BIT_TXFD        8
`define PAL_BIT_TX          7
`define PAL_BIT_TENFD       6
`define PAL_BIT_TEN         5
`define PAL_SEL_HI          4
`define PAL_SEL_LO          0
`define PAL_RSVD_VAL        1'h0
`define PAL_PAGE_RST        16'h0000

// ----------------------------------------------------------------
// control and status fields
// ----------------------------------------------------------------
`define PAL_CTRL_NPEN       0
`define PAL_CTRL_CLR        1
`define PAL_CTRL_RST        1'h0
`define PAL_ST_BASEV        0
`define PAL_ST_NEXTV        1
`define PAL_ST_VIEWN        2
`define PAL_ST_ANDONE       3
`define PAL_ST_CNT_LO       8
`define PAL_ST_CNT_HI       15
`define PAL_CNT_W           8
`define PAL_CNT_RST         8'h00
`define PAL_CNT_ONE         8'h01
`define PAL_CNT_MAX         8'hff
`define PAL_ZERO32          32'h00000000

`endif

// ---- logic/pal_page_store.v ----
// holder for the last received base page and next page words
`include "pal_defs.vh"

module pal_page_store (
	// clock and reset
	input  wire                     pclk,
	input  wire                     presetn,
	// page capture
	input  wire                     page_valid,
	input  wire                     page_is_next,
	input  wire [`PAL_PAGE_W-1:0]   page_word,
	input  wire                     clear,
	// stored pages
	output reg  [`PAL_PAGE_W-1:0]   base_reg,
	output reg  [`PAL_PAGE_W-1:0]   next_reg,
	output reg                      base_valid_reg,
	output reg                      next_valid_reg
);

	// ------------------------------------------------------------
	// whole-word capture
	// ------------------------------------------------------------
	// a new page beats a clear in the same cycle, so no page is lost
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			base_reg       <= `PAL_PAGE_RST;
			next_reg       <= `PAL_PAGE_RST;
			base_valid_reg <= 1'b0;
			next_valid_reg <= 1'b0;
		end else if (page_valid && !page_is_next) begin
			base_reg       <= page_word;
			base_valid_reg <= 1'b1;
			next_valid_reg <= 1'b0;
		end else if (page_valid && page_is_next) begin
			next_reg       <= page_word;
			next_valid_reg <= 1'b1;
		end else if (clear) begin
			base_valid_reg <= 1'b0;
			next_valid_reg <= 1'b0;
		end
	end

endmodule

// ---- logic/pal_apb_port.v ----
// registered apb answer path with zero wait states
`include "pal_defs.vh"

module pal_apb_port (
	// clock and reset
	input  wire                     pclk,
	input  wire                     presetn,
	// apb request
	input  wire                     psel,
	input  wire                     penable,
	// answer from decode
	input  wire [`PAL_DATA_W-1:0]   rd_data,
	input  wire                     rd_err,
	// apb answer
	output reg                      pready_reg,
	output reg  [`PAL_DATA_W-1:0]   prdata_reg,
	output reg                      pslverr_reg,
	output wire                     access
);

	// ------------------------------------------------------------
	// answer registers
	// ------------------------------------------------------------
	// data is latched in the setup cycle so pready can rise at once
	wire setup;

	assign setup  = psel & ~penable;
	assign access = psel & penable & pready_reg;

	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready_reg  <= 1'b0;
			prdata_reg  <= `PAL_ZERO32;
			pslverr_reg <= 1'b0;
		end else if (setup) begin
			pready_reg  <= 1'b1;
			prdata_reg  <= rd_data;
			pslverr_reg <= rd_err;
		end else begin
			pready_reg  <= 1'b0;
			prdata_reg  <= `PAL_ZERO32;
			pslverr_reg <= 1'b0;
		end
	end

endmodule

// ---- tb/pal_checker.sv ----
// port level assertions for the partner ability register bank
`include "pal_defs.vh"
module pal_checker (
	// clock and reset
	input logic                   pclk,
	input logic                   presetn,
	// apb
	input logic                   psel,
	input logic                   penable,
	input logic                   pwrite,
	input logic [`PAL_ADDR_W-1:0] paddr,
	input logic [`PAL_DATA_W-1:0] pwdata,
	input logic [`PAL_DATA_W-1:0] prdata,
	input logic                   pready,
	input logic                   pslverr,
	// engine and status
	input logic                   page_valid,
	input logic                   page_is_next,
	input logic [`PAL_PAGE_W-1:0] page_word,
	input logic                   an_complete,
	input logic                   an_restart,
	input logic                   next_page_support_reg,
	input logic                   view_is_next_reg,
	input logic                   partner_next_page_req_reg
);
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	logic [`PAL_IDX_W-1:0] idx;
	logic                  mapped;
	logic                  view_rd;
	assign idx = paddr[`PAL_IDX_HI:`PAL_IDX_LO];
	assign mapped = idx == `PAL_VIEW_INDEX ||
		(idx >= `PAL_CTRL_INDEX && idx <= `PAL_NEXT_INDEX);
	assign view_rd = pready && !pwrite && idx == `PAL_VIEW_INDEX;
	sequence s_setup;
		psel && !penable;
	endsequence
	sequence s_base_pg;
		page_valid && !page_is_next && !next_page_support_reg;
	endsequence
	sequence s_restart;
		an_restart && !page_valid ##1 !page_valid;
	endsequence
	property p_ready_first;
		s_setup |=> pready && psel && penable;
	endproperty
	property p_ready_once;
		pready |=> !pready;
	endproperty
	property p_idle_zero;
		!pready |-> prdata == 32'h0 && !pslverr;
	endproperty
	property p_err_map;
		pready |-> pslverr == !mapped;
	endproperty
	property p_rsvd;
		view_rd |-> prdata[12] == 1'b0 && prdata[31:16] == 16'h0;
	endproperty
	property p_np_view;
		view_rd |-> prdata[15] == $past(partner_next_page_req_reg);
	endproperty
	property p_base_np;
		s_base_pg |=> ##1
			partner_next_page_req_reg == $past(page_word[15], 2);
	endproperty
	property p_next_gate;
		(!next_page_support_reg or (!an_complete ##1 !an_complete))
			|=> !view_is_next_reg;
	endproperty
	property p_restart;
		s_restart |=> !view_is_next_reg && !partner_next_page_req_reg;
	endproperty
	a_ready_first: assert property (p_ready_first)
		else $error("no ready in first access cycle");
	a_ready_once: assert property (p_ready_once)
		else $error("ready held past one cycle");
	a_idle_zero: assert property (p_idle_zero)
		else $error("read data or error outside answer");
	a_err_map: assert property (p_err_map)
		else $error("error flag wrong for address");
	a_rsvd: assert property (p_rsvd)
		else $error("reserved view bits not zero");
	a_np_view: assert property (p_np_view)
		else $error("view bit 15 differs from request flag");
	a_base_np: assert property (p_base_np)
		else $error("request flag not taken from base page");
	a_next_gate: assert property (p_next_gate)
		else $error("next page shown without support and done");
	a_restart: assert property (p_restart)
		else $error("restart did not clear the view");
endmodule

// ---- tb/pal_engine_model.sv ----
// negotiation engine stand-in delivering received partner pages
`include "pal_defs.vh"
module pal_engine_model (
	// clock
	input  logic                   pclk,
	// engine outputs
	output logic                   page_valid,
	output logic                   page_is_next,
	output logic [`PAL_PAGE_W-1:0] page_word,
	output logic                   an_complete,
	output logic                   an_restart
);
	timeunit 1ns;
	timeprecision 1ns;
	initial begin
		page_valid = 1'b0;
		page_is_next = 1'b0;
		page_word = 16'h0000;
		an_complete = 1'b0;
		an_restart = 1'b0;
	end
	// ack and abilities arrive only inside a received page
	task automatic send_page(input logic nxt, input logic [15:0] w);
		@(posedge pclk);
		page_valid <= 1'b1;
		page_is_next <= nxt;
		page_word <= w;
		@(posedge pclk);
		page_valid <= 1'b0;
		// released word is junk so a stale value cannot pass
		page_word <= ~w;
		page_is_next <= ~nxt;
	endtask
	task automatic set_done(input logic d);
		@(posedge pclk);
		an_complete <= d;
	endtask
	task automatic restart();
		@(posedge pclk);
		an_restart <= 1'b1;
		@(posedge pclk);
		an_restart <= 1'b0;
	endtask
endmodule

// ---- tb/partner_ability_register_tb_top.sv ----
// self-checking bench for the partner ability register bank
`include "pal_defs.vh"
module partner_ability_register_tb_top;
	timeunit 1ns;
	timeprecision 1ns;
	localparam logic [11:0] VIEW_A = 12'h014;
	localparam logic [11:0] CTRL_A = 12'h040;
	logic        pclk = 1'b0;
	logic        presetn = 1'b0;
	logic        psel = 1'b0;
	logic        penable = 1'b0;
	logic        pwrite = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	logic        page_valid, page_is_next, an_complete, an_restart;
	logic [15:0] page_word;
	logic        np_sup, v_next, np_req;
	logic [31:0] rd;
	logic        er;
	logic [15:0] w;
	int          mismatches = 0;
	int          cmp_count = 0;
	always #50 pclk = ~pclk;
	pal_partner_ability i_dut (.pclk(pclk), .presetn(presetn),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .page_valid(page_valid),
		.page_is_next(page_is_next), .page_word(page_word),
		.an_complete(an_complete), .an_restart(an_restart),
		.next_page_support_reg(np_sup), .view_is_next_reg(v_next),
		.partner_next_page_req_reg(np_req));
	pal_engine_model i_eng (.pclk(pclk), .page_valid(page_valid),
		.page_is_next(page_is_next), .page_word(page_word),
		.an_complete(an_complete), .an_restart(an_restart));
	task automatic stop_test();
		$display("mismatches %0d comparisons %0d", mismatches, cmp_count);
		if (mismatches == 0 && cmp_count > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	task automatic check(input string nm, input logic [31:0] exp,
		input logic [31:0] got);
		cmp_count++;
		if (got !== exp) begin
			mismatches++;
			$display("[FAIL] %s expected %h seen %h", nm, exp, got);
		end
	endtask
	task automatic apb(input logic wr, input logic [11:0] a,
		input logic [31:0] d);
		int n;
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		if (n >= 20) begin
			mismatches++;
			stop_test();
		end
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	initial begin
		repeat (20) @(posedge pclk);
		presetn <= 1'b1;
		apb(1'b0, VIEW_A, 32'h0);
		check("view reset", 32'h0, rd);
		for (int i = 0; i < 16; i++) begin
			w = 16'h0001 << i;
			i_eng.send_page(1'b0, w);
			repeat (2) @(posedge pclk);
			apb(1'b0, VIEW_A, 32'h0);
			check("view hi", {24'h0, w[15:8] & 8'hef}, {24'h0, rd[15:8]});
			check("view lo", {24'h0, w[7:0]}, {rd[31:16], 8'h0, rd[7:0]});
		end
		i_eng.send_page(1'b0, 16'hffff);
		i_eng.send_page(1'b0, 16'h1421);
		repeat (2) @(posedge pclk);
		apb(1'b0, VIEW_A, 32'h0);
		check("last page", 32'h0421, rd);
		apb(1'b1, VIEW_A, 32'hffffffff);
		check("view write err", 32'h0, {31'h0, er});
		apb(1'b0, VIEW_A, 32'h0);
		check("view after write", 32'h0421, rd);
		apb(1'b0, 12'h018, 32'h0);
		check("unmapped err", 32'h1, {31'h0, er});
		check("unmapped data", 32'h0, rd);
		apb(1'b1, CTRL_A, 32'h1);
		i_eng.send_page(1'b0, 16'h8001);
		i_eng.send_page(1'b1, 16'hc5a3);
		i_eng.set_done(1'b1);
		repeat (3) @(posedge pclk);
		apb(1'b0, VIEW_A, 32'h0);
		check("next view", 32'hc5a3, rd);
		check("view is next", 32'h1, {31'h0, v_next});
		check("np request", 32'h1, {31'h0, np_req});
		i_eng.set_done(1'b0);
		repeat (3) @(posedge pclk);
		apb(1'b0, VIEW_A, 32'h0);
		check("base again", 32'h8001, rd);
		apb(1'b0, 12'h048, 32'h0);
		check("base shadow", 32'h8001, rd);
		apb(1'b0, 12'h04c, 32'h0);
		check("next shadow", 32'hc5a3, rd);
		apb(1'b0, 12'h044, 32'h0);
		check("status", 32'h1403, rd);
		apb(1'b1, CTRL_A, 32'h3);
		apb(1'b0, VIEW_A, 32'h0);
		check("view after clear", 32'h0, rd);
		apb(1'b0, CTRL_A, 32'h0);
		check("ctrl readback", 32'h1, rd);
		i_eng.send_page(1'b0, 16'h8001);
		repeat (2) @(posedge pclk);
		i_eng.restart();
		repeat (3) @(posedge pclk);
		apb(1'b0, VIEW_A, 32'h0);
		check("after restart", 32'h0, rd);
		stop_test();
	end
endmodule
bind pal_partner_ability pal_checker i_chk (.pclk(pclk), .presetn(presetn),
	.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
	.pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
	.page_valid(page_valid), .page_is_next(page_is_next),
	.page_word(page_word), .an_complete(an_complete),
	.an_restart(an_restart), .next_page_support_reg(next_page_support_reg),
	.view_is_next_reg(view_is_next_reg),
	.partner_next_page_req_reg(partner_next_page_req_reg));
